// File: hw/ucmrx_core.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module ucmrx_core
    import ucmrx_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    // Interrupt
    output logic                   irq,
    // USB engine, receive endpoint
    input  wire logic              usbRxValid,
    input  wire logic [7:0]        usbRxData,
    // USB engine, mailbox endpoint
    input  wire logic [2:0]        usbMbxIdx,
    input  wire logic              usbMbxRdDone,
    output logic      [7:0]        usbMbxData,
    // Descriptor values
    output logic      [7:0]        ep2PollInterval,
    output logic      [7:0]        ep3MaxPacket
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic              waitReq_q;
    logic [DATA_W-1:0] readData_q;
    logic              reqAny;
    logic              accept;
    logic              done;
    logic [IDX_W-1:0]  addrIdx;
    logic              wrLane0;
    logic              rdDone;
    logic [7:0]        wrByte;
    logic              hitIdx;
    logic              hitMbx;
    logic              hitPoll;
    logic              hitRxData;
    logic              hitRxCnt;
    logic              hitRxSts;
    logic              hitMps;
    logic              hitIrqSts;
    logic              hitIrqMask;
    logic              hitAfThr;

    assign reqAny     = avs_read || avs_write;
    assign accept     = reqAny && waitReq_q;
    assign done       = reqAny && !waitReq_q;
    assign addrIdx    = avs_address[ADDR_W-1:2];
    assign wrByte     = avs_writedata[7:0];
    assign wrLane0    = avs_write && done && avs_byteenable[0];
    assign rdDone     = avs_read && done;
    assign hitIdx     = (addrIdx == REG_MBX_INDEX);
    assign hitMbx     = (addrIdx == REG_MBX_DATA);
    assign hitPoll    = (addrIdx == REG_POLL_INTVL);
    assign hitRxData  = (addrIdx == REG_RX_DATA);
    assign hitRxCnt   = (addrIdx == REG_RX_COUNT);
    assign hitRxSts   = (addrIdx == REG_RX_STATUS);
    assign hitMps     = (addrIdx == REG_RX_MAXPKT);
    assign hitIrqSts  = (addrIdx == REG_IRQ_STATUS);
    assign hitIrqMask = (addrIdx == REG_IRQ_MASK);
    assign hitAfThr   = (addrIdx == REG_AF_THRESH);

    // Two-phase handshake: accept, then complete
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            waitReq_q <= 1'b1;
        else
            waitReq_q <= !accept;
    end

    // ****************************************************************
    // Mailboxes
    // ****************************************************************
    logic [7:0]           mbx_q [MBX_DEPTH];
    logic [MBX_IDX_W-1:0] idx_q;
    logic [MBX_IDX_W-1:0] idx_d;
    logic [MBX_IDX_W-1:0] idxInc;
    logic                 mbxAccess;
    logic [7:0]           mbxSel;
    logic [7:0]           hostSel;
    logic [7:0]           usbMbxData_q;

    assign mbxAccess = done && hitMbx;
    assign mbxSel    = mbx_q[idx_q];
    assign hostSel   = mbx_q[usbMbxIdx];
    assign idxInc    = (idx_q == MBX_IDX_MAX) ? MBX_IDX_RST : idx_q + 3'h1;
    assign idx_d     = (wrLane0 && hitIdx) ? wrByte[2:0] :
                       mbxAccess           ? idxInc      : idx_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            idx_q <= MBX_IDX_RST;
        else
            idx_q <= idx_d;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mbx_q <= '{default: 8'h00};
        else if (wrLane0 && hitMbx)
            mbx_q[idx_q] <= wrByte;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            usbMbxData_q <= 8'h00;
        else
            usbMbxData_q <= hostSel;
    end

    assign usbMbxData = usbMbxData_q;

    // ****************************************************************
    // Plain control registers
    // ****************************************************************
    logic [7:0]       poll_q;
    logic [7:0]       mps_q;
    logic [7:0]       afThr_q;
    logic [IRQ_W-1:0] irqMask_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            poll_q <= POLL_INTVL_RST;
        else if (wrLane0 && hitPoll)
            poll_q <= wrByte;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mps_q <= MAXPKT_RST;
        else if (wrLane0 && hitMps)
            mps_q <= wrByte;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            afThr_q   <= AF_THRESH_RST;
            irqMask_q <= IRQ_MASK_RST;
        end
        else
        begin
            if (wrLane0 && hitAfThr)
                afThr_q <= wrByte;
            if (wrLane0 && hitIrqMask)
                irqMask_q <= wrByte[IRQ_W-1:0];
        end
    end

    assign ep2PollInterval = poll_q;
    // eight-byte units out to the descriptor
    assign ep3MaxPacket    = mps_q;

    // ****************************************************************
    // Receive FIFO and flags
    // ****************************************************************
    logic [7:0]       fifoHead;
    logic [CNT_W-1:0] fifoCount;
    logic             fifoFull;
    logic             fifoEmpty;
    logic             rdEmpty_q;
    logic             rxRead;
    logic             rxPop;
    logic             flush;
    logic [1:0]       rxSet;
    logic [1:0]       rxClr;
    logic [1:0]       rxFlags;

    assign rxRead = rdDone && hitRxData;
    assign rxPop  = rxRead && !rdEmpty_q;
    // flush on writing one to the flush bit
    assign flush  = wrLane0 && hitRxSts && wrByte[STS_FLUSH];
    // overflow on host write into full FIFO
    assign rxSet[1] = usbRxValid && fifoFull;
    // underflow on read of empty FIFO
    assign rxSet[0] = rxRead && rdEmpty_q;
    assign rxClr    = (wrLane0 && hitRxSts) ? wrByte[STS_OVER:STS_UNDER] : 2'h0;

    // Emptiness frozen at accept so data and pop agree
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdEmpty_q <= 1'b1;
        else if (accept)
            rdEmpty_q <= fifoEmpty;
    end

    ucmrx_fifo u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .pushValid (usbRxValid),
        .pushData  (usbRxData),
        .popReq    (rxPop),
        .flush     (flush),
        .headData  (fifoHead),
        .count_q   (fifoCount),
        .full      (fifoFull),
        .empty     (fifoEmpty)
    );

    ucmrx_sticky #(.WIDTH(2)) u_rxFlags (
        .core_clk (core_clk),
        .rst      (rst),
        .setPulse (rxSet),
        .clrMask  (rxClr),
        .flags_q  (rxFlags)
    );

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;
    logic [IRQ_W-1:0] irqSts;
    logic             irq_q;

    // count at threshold and one more byte arrives
    assign irqSet[IRQ_ALMOST_FULL] = usbRxValid && !fifoFull && !flush &&
                                     ({1'b0, fifoCount} == afThr_q);
    assign irqSet[IRQ_MBX_READ]    = usbMbxRdDone;
    assign irqClr = (wrLane0 && hitIrqSts) ? wrByte[IRQ_W-1:0] : '0;

    ucmrx_sticky #(.WIDTH(IRQ_W)) u_irqFlags (
        .core_clk (core_clk),
        .rst      (rst),
        .setPulse (irqSet),
        .clrMask  (irqClr),
        .flags_q  (irqSts)
    );

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(irqSts & irqMask_q);
    end

    assign irq = irq_q;

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] rxStatus;
    logic [7:0] rdMux;

    // live full and empty, flush reads zero
    assign rxStatus = {3'h0, 1'b0, rxFlags[1], rxFlags[0], fifoFull, fifoEmpty};
    assign rdMux = hitIdx     ? {5'h00, idx_q}            :
                   hitMbx     ? mbxSel                    :
                   hitPoll    ? poll_q                    :
                   hitRxData  ? (fifoEmpty ? 8'h00 : fifoHead) :
                   hitRxCnt   ? {1'b0, fifoCount}         :
                   hitRxSts   ? rxStatus                  :
                   hitMps     ? mps_q                     :
                   hitIrqSts  ? {6'h00, irqSts}           :
                   hitIrqMask ? {6'h00, irqMask_q}        :
                   hitAfThr   ? afThr_q                   : 8'h00;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            readData_q <= 32'h0000_0000;
        else if (accept && avs_read)
            readData_q <= {24'h00_0000, rdMux};
    end

    assign avs_readdata    = readData_q;
    assign avs_waitrequest = waitReq_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence sAccept;
        accept ##1 (reqAny && !avs_waitrequest);
    endsequence

    a_bus_answer: assert property (accept |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_idx_select: assert property (sAccept and (avs_read && hitMbx) |->
                                   ##1 avs_readdata[7:0] == $past(mbxSel, 2))
        else $error("mailbox read returned wrong byte");
    a_idx_advance: assert property (mbxAccess && idx_q != MBX_IDX_MAX |=>
                                    idx_q == $past(idx_q) + 3'h1)
        else $error("mailbox index did not advance");
    a_idx_wrap: assert property (mbxAccess && idx_q == MBX_IDX_MAX |=> idx_q == 3'h0)
        else $error("mailbox index did not wrap");
    a_host_mbx: assert property (##1 usbMbxData == $past(hostSel))
        else $error("host mailbox data mismatch");
    a_irq_level: assert property (##1 irq == $past(|(irqSts & irqMask_q)))
        else $error("interrupt not raised");
    a_mbx_event: assert property (usbMbxRdDone |=> irqSts[IRQ_MBX_READ])
        else $error("mailbox read event lost");
    a_poll_write: assert property (wrLane0 && hitPoll |=> poll_q == $past(wrByte))
        else $error("polling interval not written");
    a_rx_pop: assert property (rxPop && !usbRxValid |=> fifoCount == $past(fifoCount) - 7'h1)
        else $error("read did not drain one byte");
    a_count_range: assert property (fifoCount <= FIFO_FULL_CNT)
        else $error("count beyond sixty-four");
    a_flush_empty: assert property (flush |=> fifoCount == 7'h00 && fifoEmpty)
        else $error("flush left data");
    a_over_sticky: assert property (usbRxValid && fifoFull |=> rxFlags[1] [*2] or
                                    (rxFlags[1] ##1 1'b1))
        else $error("overflow not flagged");
    a_under_flag: assert property (rxRead && rdEmpty_q |=> rxFlags[0] &&
        fifoCount == $past(fifoCount) + 7'($past(usbRxValid && !fifoFull)))
        else $error("underflow not flagged or count moved");
    a_full_empty: assert property (rxStatus[STS_FULL] == (fifoCount == FIFO_FULL_CNT) &&
                                   rxStatus[STS_EMPTY] == (fifoCount == 7'h00))
        else $error("full or empty flag wrong");
    a_mps_write: assert property (wrLane0 && hitMps |=> ep3MaxPacket == $past(wrByte))
        else $error("packet size not written");
    a_afull_set: assert property (irqSet[IRQ_ALMOST_FULL] |=> irqSts[IRQ_ALMOST_FULL])
        else $error("almost-full not flagged");

endmodule // ucmrx_core
`default_nettype wire

// File: hw/ucmrx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Byte FIFO with count and flush
// ****************************************************************
module ucmrx_fifo
    import ucmrx_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             pushValid,
    input  wire logic [7:0]       pushData,
    // Drain side
    input  wire logic             popReq,
    input  wire logic             flush,
    output logic      [7:0]       headData,
    // Occupancy
    output logic      [CNT_W-1:0] count_q,
    output logic                  full,
    output logic                  empty
);

    logic [7:0]       mem_q [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic             doPush;
    logic             doPop;

    assign full     = (count_q == FIFO_FULL_CNT);
    assign empty    = (count_q == '0);
    assign doPush   = pushValid && !full && !flush;
    assign doPop    = popReq && !empty && !flush;
    assign headData = mem_q[rdPtr_q];

    always_ff @(posedge core_clk)
    begin
        if (doPush)
            mem_q[wrPtr_q] <= pushData;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else if (flush)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_q + PTR_W'(doPush);
            rdPtr_q <= rdPtr_q + PTR_W'(doPop);
            count_q <= count_q + CNT_W'(doPush) - CNT_W'(doPop);
        end
    end

endmodule // ucmrx_fifo
`default_nettype wire

// File: hw/ucmrx_pkg.sv
// ****************************************************************
// Shared constants
// ****************************************************************
package ucmrx_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W  = 16;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] REG_MBX_INDEX  = 16'h4018;
    localparam logic [IDX_W-1:0] REG_MBX_DATA   = 16'h401a;
    localparam logic [IDX_W-1:0] REG_POLL_INTVL = 16'h401c;
    localparam logic [IDX_W-1:0] REG_RX_DATA    = 16'h4020;
    localparam logic [IDX_W-1:0] REG_RX_COUNT   = 16'h4022;
    localparam logic [IDX_W-1:0] REG_RX_STATUS  = 16'h4024;
    localparam logic [IDX_W-1:0] REG_RX_MAXPKT  = 16'h4026;
    localparam logic [IDX_W-1:0] REG_IRQ_STATUS = 16'h4040;
    localparam logic [IDX_W-1:0] REG_IRQ_MASK   = 16'h4041;
    localparam logic [IDX_W-1:0] REG_AF_THRESH  = 16'h4042;

    // Mailbox geometry
    localparam int unsigned     MBX_DEPTH = 8;
    localparam int unsigned     MBX_IDX_W = 3;
    localparam logic [2:0]      MBX_IDX_MAX = 3'h7;
    localparam logic [2:0]      MBX_IDX_RST = 3'h0;

    // Receive FIFO geometry
    localparam int unsigned     FIFO_DEPTH = 64;
    localparam int unsigned     PTR_W      = 6;
    localparam int unsigned     CNT_W      = 7;
    localparam logic [6:0]      FIFO_FULL_CNT = 7'h40;

    // Receive status field positions
    localparam int unsigned STS_EMPTY = 0;
    localparam int unsigned STS_FULL  = 1;
    localparam int unsigned STS_UNDER = 2;
    localparam int unsigned STS_OVER  = 3;
    localparam int unsigned STS_FLUSH = 4;

    // Interrupt status field positions
    localparam int unsigned IRQ_W          = 2;
    localparam int unsigned IRQ_ALMOST_FULL = 0;
    localparam int unsigned IRQ_MBX_READ   = 1;

    // Reset values
    localparam logic [7:0] POLL_INTVL_RST = 8'hff;
    localparam logic [7:0] MAXPKT_RST     = 8'h08;
    localparam logic [7:0] AF_THRESH_RST  = 8'h30;
    localparam logic [1:0] IRQ_MASK_RST   = 2'h0;
    localparam logic [7:0] RX_STATUS_RST  = 8'h01;

endpackage : ucmrx_pkg

// File: hw/ucmrx_sticky.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Sticky flag bank, write-one-to-clear, set wins
// ****************************************************************
module ucmrx_sticky
    import ucmrx_pkg::*;
#(
    parameter int unsigned WIDTH = 2
)
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Events and clears
    input  wire logic [WIDTH-1:0] setPulse,
    input  wire logic [WIDTH-1:0] clrMask,
    // Flags
    output logic      [WIDTH-1:0] flags_q
);

    logic [WIDTH-1:0] flags_d;

    assign flags_d = (flags_q & ~clrMask) | setPulse;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

endmodule // ucmrx_sticky
`default_nettype wire

// File: verification/ucmrx_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Host side of both endpoints
// ****************************************************************
module ucmrx_host_model
(
    // Clock
    input  wire logic       core_clk,
    // Receive endpoint
    output logic            usbRxValid,
    output logic      [7:0] usbRxData,
    // Mailbox endpoint
    output logic      [2:0] usbMbxIdx,
    output logic            usbMbxRdDone,
    input  wire logic [7:0] usbMbxData
);
    initial
    begin
        usbRxValid = 1'b0;
        usbRxData = 8'h00;
        usbMbxIdx = 3'h0;
        usbMbxRdDone = 1'b0;
    end
    task automatic push(input logic [7:0] b);
        @(posedge core_clk);
        usbRxValid <= 1'b1;
        usbRxData <= b;
    endtask
    // Released data line shows no stale byte
    task automatic idle();
        @(posedge core_clk);
        usbRxValid <= 1'b0;
        usbRxData <= ~usbRxData;
    endtask
    task automatic fetch(input logic [2:0] i, output logic [7:0] d);
        @(posedge core_clk);
        usbMbxIdx <= i;
        @(posedge core_clk);
        usbMbxIdx <= ~i;
        @(negedge core_clk);
        d = usbMbxData;
    endtask
    task automatic done();
        @(posedge core_clk);
        usbMbxRdDone <= 1'b1;
        @(posedge core_clk);
        usbMbxRdDone <= 1'b0;
    endtask
endmodule // ucmrx_host_model
`default_nettype wire

// File: verification/usb_client_mailbox_rx_fifo_tb.sv
`timescale 1ns/10ps
`default_nettype none
module usb_client_mailbox_rx_fifo_tb;
    import ucmrx_pkg::*;
    logic core_clk, rst, avs_read, avs_write, irq, usbRxValid, usbMbxRdDone;
    logic avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] usbRxData, usbMbxData, ep2PollInterval, ep3MaxPacket;
    logic [2:0] usbMbxIdx;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    ucmrx_core dut_u (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .usbRxValid(usbRxValid),
        .usbRxData(usbRxData), .usbMbxIdx(usbMbxIdx), .usbMbxRdDone(usbMbxRdDone),
        .usbMbxData(usbMbxData), .ep2PollInterval(ep2PollInterval),
        .ep3MaxPacket(ep3MaxPacket));
    ucmrx_host_model host_u (.core_clk(core_clk), .usbRxValid(usbRxValid),
        .usbRxData(usbRxData), .usbMbxIdx(usbMbxIdx), .usbMbxRdDone(usbMbxRdDone),
        .usbMbxData(usbMbxData));
    // ****************************************************************
    // Clock, timeout and checking helpers
    // ****************************************************************
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Hold the request until waitrequest is seen low
    task automatic xfer(input logic w, input logic [15:0] r, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= {r, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, d};
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] r, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, r, d, q);
    endtask
    task automatic rd(input logic [15:0] r, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, r, 8'h00, q);
        chk(q, e);
    endtask
    task automatic irqIs(input logic e);
        @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    function automatic logic [31:0] sts(input int c, input logic o, input logic u);
        return {24'h0, 4'h0, o, u, c == 64, c == 0};
    endfunction
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    logic [15:0] rAddr [8] = '{REG_MBX_INDEX, REG_MBX_DATA, REG_POLL_INTVL, REG_RX_COUNT,
        REG_RX_STATUS, REG_RX_MAXPKT, REG_AF_THRESH, 16'h4030};
    logic [7:0] rExp [8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h01, 8'h08, AF_THRESH_RST, 8'h00};
    initial
    begin
        logic [7:0] mb [8];
        logic [7:0] q [$];
        logic [7:0] b;
        logic [31:0] v;
        int n;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        void'($urandom(32'h6ee1));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++)
            rd(rAddr[k], {24'h0, rExp[k]});
        chk({24'h0, ep2PollInterval}, 32'hff);
        chk({24'h0, ep3MaxPacket}, 32'h08);
        v = $urandom;
        wr(REG_POLL_INTVL, v[7:0]);
        wr(REG_RX_MAXPKT, v[15:8]);
        rd(REG_RX_MAXPKT, {24'h0, v[15:8]});
        chk({24'h0, ep2PollInterval}, {24'h0, v[7:0]});
        chk({24'h0, ep3MaxPacket}, {24'h0, v[15:8]});
        // Start at six so the wrap shows
        wr(REG_MBX_INDEX, 8'h06);
        for (int k = 0; k < 8; k++)
        begin
            mb[(k + 6) % 8] = 8'($urandom);
            wr(REG_MBX_DATA, mb[(k + 6) % 8]);
        end
        rd(REG_MBX_INDEX, 32'h6);
        for (int k = 0; k < 8; k++)
        begin
            host_u.fetch(k[2:0], b);
            chk({24'h0, b}, {24'h0, mb[k]});
        end
        wr(REG_MBX_INDEX, 8'h03);
        for (int k = 0; k < 8; k++)
            rd(REG_MBX_DATA, {24'h0, mb[(k + 3) % 8]});
        // Byte lane 0 off: no store, index still moves
        avs_byteenable <= 4'he;
        wr(REG_MBX_DATA, 8'h5a);
        avs_byteenable <= 4'hf;
        rd(REG_MBX_INDEX, 32'h4);
        wr(REG_MBX_INDEX, 8'h03);
        rd(REG_MBX_DATA, {24'h0, mb[3]});
        host_u.done();
        irqIs(1'b0);
        rd(REG_IRQ_STATUS, 32'h2);
        wr(REG_IRQ_MASK, 8'h02);
        irqIs(1'b1);
        wr(REG_IRQ_STATUS, 8'h02);
        irqIs(1'b0);
        // Fill past full
        for (int k = 0; k < 65; k++)
        begin
            b = 8'($urandom);
            host_u.push(b);
            if (k < 64)
                q.push_back(b);
        end
        host_u.idle();
        rd(REG_IRQ_STATUS, 32'h1);
        rd(REG_RX_COUNT, 32'h40);
        rd(REG_RX_STATUS, sts(64, 1'b1, 1'b0));
        for (int k = 0; k < 64; k++)
            rd(REG_RX_DATA, {24'h0, q.pop_front()});
        rd(REG_RX_DATA, 32'h0);
        rd(REG_RX_COUNT, 32'h0);
        rd(REG_RX_STATUS, sts(0, 1'b1, 1'b1));
        wr(REG_RX_STATUS, 8'h0c);
        rd(REG_RX_STATUS, sts(0, 1'b0, 1'b0));
        n = 1 + ($urandom % 63);
        for (int k = 0; k < n; k++)
        begin
            b = 8'($urandom);
            host_u.push(b);
        end
        host_u.idle();
        rd(REG_RX_COUNT, n);
        wr(REG_RX_STATUS, 8'h10);
        rd(REG_RX_COUNT, 32'h0);
        rd(REG_RX_STATUS, sts(0, 1'b0, 1'b0));
        test_done();
    end
endmodule // usb_client_mailbox_rx_fifo_tb
`default_nettype wire
